/* File: bf_map.svh */
// Offsets, field positions, reset values and timing counts of the breaker failure logic
// Behaviour
// - Modes off, current, contact, both; off never trips
// - Start rising edge launches backup and retrip timers
// - Backup trip when supervised fault persists at expiry
// - Retrip per phase at retrip delay when enabled
// - Retrip enable off or on, off after reset
// - Retrip delay 0 to 1000 ms, default 100
// - Backup delay 100 to 60000 ms, default 1000
// - Trip held at least the pulse duration
// - Inhibit input suppresses every trip output
// - Outside logic gives one common breaker-closed input
// - Outside logic gives three per-phase breaker-closed inputs
// - Outside logic drives per-phase start inputs
// - Residual start input, supervised per mode by residual comparison, any breaker-closed input, or either
// - One backup trip output for backup breakers
// - Three independent per-phase retrip outputs
// - Event on every rise and fall of outputs
// - Delay measured from the start input's rising edge
// - Processing latency absorbed inside the programmed delay
`ifndef BF_MAP_SVH
`define BF_MAP_SVH
`define BF_CLK_MHZ 20
`define BF_TICK_US 1000
`define BF_TICK_CYCLES (`BF_TICK_US * `BF_CLK_MHZ)
`define BF_RETRIP_EN_RST 1'b0
`define BF_RETRIP_DLY_RST 16'h0064
`define BF_RETRIP_DLY_MAX 16'h03e8
`define BF_BACKUP_DLY_RST 16'h03e8
`define BF_BACKUP_DLY_MIN 16'h0064
`define BF_BACKUP_DLY_MAX 16'hea60
`define BF_PULSE_RST 16'h0064
`define BF_PULSE_MAX 16'hea60
`define BF_PH_THR_RST 16'h001e
`define BF_PH_THR_MIN 16'h0014
`define BF_PH_THR_MAX 16'h00c8
`define BF_RES_THR_RST 16'h0014
`define BF_RES_THR_MIN 16'h000a
`define BF_RES_THR_MAX 16'h00c8
`define BF_HYST_NUM 4'h9
`define BF_HYST_DEN 4'ha
`define BF_OFS_CTRL 8'h00
`define BF_OFS_MODE 8'h04
`define BF_OFS_RETRIP_DLY 8'h08
`define BF_OFS_BACKUP_DLY 8'h0c
`define BF_OFS_PULSE 8'h10
`define BF_OFS_PH_THR 8'h14
`define BF_OFS_RES_THR 8'h18
`define BF_OFS_STATUS 8'h1c
`define BF_CTRL_COMMON_START 0
`define BF_CTRL_START_PH1 1
`define BF_CTRL_START_PH2 2
`define BF_CTRL_START_PH3 3
`define BF_CTRL_RES_START 4
`define BF_CTRL_INHIBIT 5
`define BF_CTRL_CLOSED 6
`define BF_CTRL_CLOSED_PH1 7
`define BF_CTRL_CLOSED_PH2 8
`define BF_CTRL_CLOSED_PH3 9
`define BF_MODE_OP_LSB 0
`define BF_MODE_RETRIP_EN 4
`define BF_STAT_OUT_LSB 0
`define BF_STAT_ON_LSB 8
`define BF_STAT_OFF_LSB 12
`endif

/* File: bf_pkg.sv */
// Types shared by both ends of the breaker failure link
package bf_pkg;
  typedef enum logic [1:0] {op_off, op_current, op_contact, op_both} op_mode_type;
  typedef logic [15:0] ms_type;
endpackage : bf_pkg

/* File: bf_if.sv */
// Link between the breaker failure logic and its start and contact side
interface bf_if;
  logic common_start_in;
  logic start_ph1_in;
  logic start_ph2_in;
  logic start_ph3_in;
  logic residual_start_in;
  logic bf_inhibit_in;
  logic breaker_closed_in;
  logic breaker_closed_ph1_in;
  logic breaker_closed_ph2_in;
  logic breaker_closed_ph3_in;
  bf_pkg::op_mode_type op_mode;
  logic retrip_en;
  bf_pkg::ms_type retrip_delay;
  bf_pkg::ms_type backup_delay;
  bf_pkg::ms_type pulse_duration;
  logic [15:0] ph_threshold;
  logic [15:0] res_threshold;
  logic backup_trip_out;
  logic retrip_ph1_out;
  logic retrip_ph2_out;
  logic retrip_ph3_out;
  logic [3:0] event_on;
  logic [3:0] event_off;
  modport device (
    input common_start_in, start_ph1_in, start_ph2_in, start_ph3_in, residual_start_in,
    input bf_inhibit_in, breaker_closed_in,
    input breaker_closed_ph1_in, breaker_closed_ph2_in, breaker_closed_ph3_in,
    input op_mode, retrip_en, retrip_delay, backup_delay, pulse_duration,
    input ph_threshold, res_threshold,
    output backup_trip_out, retrip_ph1_out, retrip_ph2_out, retrip_ph3_out,
    output event_on, event_off
  );
  modport requester (
    output common_start_in, start_ph1_in, start_ph2_in, start_ph3_in, residual_start_in,
    output bf_inhibit_in, breaker_closed_in,
    output breaker_closed_ph1_in, breaker_closed_ph2_in, breaker_closed_ph3_in,
    output op_mode, retrip_en, retrip_delay, backup_delay, pulse_duration,
    output ph_threshold, res_threshold,
    input backup_trip_out, retrip_ph1_out, retrip_ph2_out, retrip_ph3_out,
    input event_on, event_off
  );
endinterface : bf_if

/* File: bf_device.sv */
// Breaker failure decision logic: timers, supervision, pulse stretch and events
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`include "bf_map.svh"
module bf_device #(
  parameter int unsigned TICK_CYCLES = `BF_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Measured currents in percent of nominal
  input wire logic [15:0] meas_ph1,
  input wire logic [15:0] meas_ph2,
  input wire logic [15:0] meas_ph3,
  input wire logic [15:0] meas_res,
  // Link to start logic and breaker contacts
  bf_if.device link
);
  logic [15:0] tick_cnt_r;
  logic tick_r;
  logic [15:0] meas [4];
  logic [15:0] thr [4];
  logic [3:0] start_cur;
  logic [3:0] closed;
  logic [3:0] over_r;
  logic [3:0] fault;
  logic [3:0] start_prev_r;
  logic [3:0] run_r;
  logic [15:0] elapsed_r [4];
  logic [3:0] backup_req;
  logic [2:0] retrip_req;
  logic [3:0] trip_req;
  logic [3:0] out_r;
  logic [3:0] out_d_r;
  logic [15:0] pulse_cnt_r [4];
  logic [3:0] ev_on_r;
  logic [3:0] ev_off_r;
  logic enabled;
  logic kill;
  bf_pkg::ms_type retrip_dly;
  bf_pkg::ms_type backup_dly;
  bf_pkg::ms_type pulse_dur;
  logic [15:0] ph_thr;
  logic [15:0] res_thr;

  // One millisecond tick
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (tick_cnt_r == 16'(TICK_CYCLES - 1))
    begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // Settings held inside their ranges
  always_comb
  begin
    retrip_dly = link.retrip_delay;
    if (link.retrip_delay > `BF_RETRIP_DLY_MAX)
    begin
      retrip_dly = `BF_RETRIP_DLY_MAX;
    end
    backup_dly = link.backup_delay;
    if (link.backup_delay < `BF_BACKUP_DLY_MIN)
    begin
      backup_dly = `BF_BACKUP_DLY_MIN;
    end
    else if (link.backup_delay > `BF_BACKUP_DLY_MAX)
    begin
      backup_dly = `BF_BACKUP_DLY_MAX;
    end
    pulse_dur = link.pulse_duration;
    if (link.pulse_duration > `BF_PULSE_MAX)
    begin
      pulse_dur = `BF_PULSE_MAX;
    end
    ph_thr = link.ph_threshold;
    if (link.ph_threshold < `BF_PH_THR_MIN)
    begin
      ph_thr = `BF_PH_THR_MIN;
    end
    else if (link.ph_threshold > `BF_PH_THR_MAX)
    begin
      ph_thr = `BF_PH_THR_MAX;
    end
    res_thr = link.res_threshold;
    if (link.res_threshold < `BF_RES_THR_MIN)
    begin
      res_thr = `BF_RES_THR_MIN;
    end
    else if (link.res_threshold > `BF_RES_THR_MAX)
    begin
      res_thr = `BF_RES_THR_MAX;
    end
  end

  // Channel inputs: three phases and residual
  assign meas[0] = meas_ph1;
  assign meas[1] = meas_ph2;
  assign meas[2] = meas_ph3;
  assign meas[3] = meas_res;
  assign thr[0] = ph_thr;
  assign thr[1] = ph_thr;
  assign thr[2] = ph_thr;
  assign thr[3] = res_thr;
  assign start_cur[0] = link.common_start_in | link.start_ph1_in;
  assign start_cur[1] = link.common_start_in | link.start_ph2_in;
  assign start_cur[2] = link.common_start_in | link.start_ph3_in;
  assign start_cur[3] = link.residual_start_in;
  assign closed[0] = link.breaker_closed_in | link.breaker_closed_ph1_in;
  assign closed[1] = link.breaker_closed_in | link.breaker_closed_ph2_in;
  assign closed[2] = link.breaker_closed_in | link.breaker_closed_ph3_in;
  assign closed[3] = link.breaker_closed_in | link.breaker_closed_ph1_in
                   | link.breaker_closed_ph2_in | link.breaker_closed_ph3_in;
  assign enabled = link.op_mode != bf_pkg::op_off;
  assign kill = link.bf_inhibit_in | ~enabled;

  // Supervision and timers per channel
  for (genvar ch = 0; ch < 4; ch++)
  begin : g_chan
    logic [19:0] meas_scaled;
    logic [19:0] thr_scaled;
    assign meas_scaled = 20'(meas[ch]) * 20'(`BF_HYST_DEN);
    assign thr_scaled = 20'(thr[ch]) * 20'(`BF_HYST_NUM);

    // Pick-up at threshold, release below nine tenths
    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        over_r[ch] <= 1'b0;
      end
      else if (meas[ch] >= thr[ch])
      begin
        over_r[ch] <= 1'b1;
      end
      else if (meas_scaled < thr_scaled)
      begin
        over_r[ch] <= 1'b0;
      end
    end

    // Supervised fault by operation selection
    always_comb
    begin
      case (link.op_mode)
        bf_pkg::op_current: fault[ch] = over_r[ch];
        bf_pkg::op_contact: fault[ch] = closed[ch];
        bf_pkg::op_both: fault[ch] = over_r[ch] | closed[ch];
        default: fault[ch] = 1'b0;
      endcase
    end

    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        start_prev_r[ch] <= 1'b0;
      end
      else
      begin
        start_prev_r[ch] <= start_cur[ch];
      end
    end

    // Timer runs from the start edge while the fault persists
    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        run_r[ch] <= 1'b0;
        elapsed_r[ch] <= 16'h0000;
      end
      else if (start_cur[ch] && !start_prev_r[ch] && !kill)
      begin
        run_r[ch] <= 1'b1;
        elapsed_r[ch] <= 16'h0000;
      end
      else if (run_r[ch] && (kill || !fault[ch]))
      begin
        run_r[ch] <= 1'b0;
      end
      else if (run_r[ch] && tick_r && elapsed_r[ch] != 16'hffff)
      begin
        elapsed_r[ch] <= elapsed_r[ch] + 16'h0001;
      end
    end

    assign backup_req[ch] = run_r[ch] && fault[ch] && elapsed_r[ch] >= backup_dly;
  end

  for (genvar ph = 0; ph < 3; ph++)
  begin : g_retrip
    assign retrip_req[ph] = run_r[ph] && fault[ph] && link.retrip_en
                          && elapsed_r[ph] >= retrip_dly;
  end

  assign trip_req[0] = |backup_req;
  assign trip_req[3:1] = retrip_req;

  // Output pulse stretch and events
  for (genvar j = 0; j < 4; j++)
  begin : g_out
    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        out_r[j] <= 1'b0;
        pulse_cnt_r[j] <= 16'h0000;
      end
      else if (kill)
      begin
        out_r[j] <= 1'b0;
        pulse_cnt_r[j] <= 16'h0000;
      end
      else if (trip_req[j])
      begin
        out_r[j] <= 1'b1;
        pulse_cnt_r[j] <= pulse_dur;
      end
      else if (out_r[j] && tick_r)
      begin
        if (pulse_cnt_r[j] == 16'h0000)
        begin
          out_r[j] <= 1'b0;
        end
        else
        begin
          pulse_cnt_r[j] <= pulse_cnt_r[j] - 16'h0001;
        end
      end
    end

    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        out_d_r[j] <= 1'b0;
        ev_on_r[j] <= 1'b0;
        ev_off_r[j] <= 1'b0;
      end
      else
      begin
        out_d_r[j] <= out_r[j];
        ev_on_r[j] <= out_r[j] & ~out_d_r[j];
        ev_off_r[j] <= ~out_r[j] & out_d_r[j];
      end
    end
  end

  assign link.backup_trip_out = out_r[0];
  assign link.retrip_ph1_out = out_r[1];
  assign link.retrip_ph2_out = out_r[2];
  assign link.retrip_ph3_out = out_r[3];
  assign link.event_on = ev_on_r;
  assign link.event_off = ev_off_r;
endmodule : bf_device

/* File: bf_requester.sv */
// Start and contact side: Avalon-MM registers that drive the breaker failure link
`include "bf_map.svh"
module bf_requester (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave, byte addressed
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Link to the breaker failure logic
  bf_if.requester link
);
  logic [9:0] ctrl_r;
  bf_pkg::op_mode_type mode_r;
  logic retrip_en_r;
  logic [15:0] retrip_dly_r;
  logic [15:0] backup_dly_r;
  logic [15:0] pulse_r;
  logic [15:0] ph_thr_r;
  logic [15:0] res_thr_r;
  logic [3:0] on_sticky_r;
  logic [3:0] off_sticky_r;
  logic [3:0] outs;
  logic [31:0] rd_nxt;
  logic wr_go;

  assign outs = {link.retrip_ph3_out, link.retrip_ph2_out, link.retrip_ph1_out,
                 link.backup_trip_out};
  assign wr_go = avs_write && !avs_waitrequest;

  // Read mux
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (avs_address == `BF_OFS_CTRL)
      rd_nxt[9:0] = ctrl_r;
    else if (avs_address == `BF_OFS_MODE)
    begin
      rd_nxt[`BF_MODE_OP_LSB +: 2] = mode_r;
      rd_nxt[`BF_MODE_RETRIP_EN] = retrip_en_r;
    end
    else if (avs_address == `BF_OFS_RETRIP_DLY)
      rd_nxt[15:0] = retrip_dly_r;
    else if (avs_address == `BF_OFS_BACKUP_DLY)
      rd_nxt[15:0] = backup_dly_r;
    else if (avs_address == `BF_OFS_PULSE)
      rd_nxt[15:0] = pulse_r;
    else if (avs_address == `BF_OFS_PH_THR)
      rd_nxt[15:0] = ph_thr_r;
    else if (avs_address == `BF_OFS_RES_THR)
      rd_nxt[15:0] = res_thr_r;
    else if (avs_address == `BF_OFS_STATUS)
    begin
      rd_nxt[`BF_STAT_OUT_LSB +: 4] = outs;
      rd_nxt[`BF_STAT_ON_LSB +: 4] = on_sticky_r;
      rd_nxt[`BF_STAT_OFF_LSB +: 4] = off_sticky_r;
    end
  end

  // One wait cycle, then the answer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else if ((avs_read || avs_write) && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_nxt;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Settings and control
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_r <= 10'h000;
      mode_r <= bf_pkg::op_off;
      retrip_en_r <= `BF_RETRIP_EN_RST;
      retrip_dly_r <= `BF_RETRIP_DLY_RST;
      backup_dly_r <= `BF_BACKUP_DLY_RST;
      pulse_r <= `BF_PULSE_RST;
      ph_thr_r <= `BF_PH_THR_RST;
      res_thr_r <= `BF_RES_THR_RST;
    end
    else if (wr_go)
    begin
      if (avs_address == `BF_OFS_CTRL)
        ctrl_r <= avs_writedata[9:0];
      else if (avs_address == `BF_OFS_MODE)
      begin
        mode_r <= bf_pkg::op_mode_type'(avs_writedata[`BF_MODE_OP_LSB +: 2]);
        retrip_en_r <= avs_writedata[`BF_MODE_RETRIP_EN];
      end
      else if (avs_address == `BF_OFS_RETRIP_DLY)
        retrip_dly_r <= avs_writedata[15:0];
      else if (avs_address == `BF_OFS_BACKUP_DLY)
        backup_dly_r <= avs_writedata[15:0];
      else if (avs_address == `BF_OFS_PULSE)
        pulse_r <= avs_writedata[15:0];
      else if (avs_address == `BF_OFS_PH_THR)
        ph_thr_r <= avs_writedata[15:0];
      else if (avs_address == `BF_OFS_RES_THR)
        res_thr_r <= avs_writedata[15:0];
    end
  end

  // Sticky events, write one to clear, new event wins
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      on_sticky_r <= 4'h0;
      off_sticky_r <= 4'h0;
    end
    else if (wr_go && avs_address == `BF_OFS_STATUS)
    begin
      on_sticky_r <= (on_sticky_r & ~avs_writedata[`BF_STAT_ON_LSB +: 4]) | link.event_on;
      off_sticky_r <= (off_sticky_r & ~avs_writedata[`BF_STAT_OFF_LSB +: 4]) | link.event_off;
    end
    else
    begin
      on_sticky_r <= on_sticky_r | link.event_on;
      off_sticky_r <= off_sticky_r | link.event_off;
    end
  end

  assign link.common_start_in = ctrl_r[`BF_CTRL_COMMON_START];
  assign link.start_ph1_in = ctrl_r[`BF_CTRL_START_PH1];
  assign link.start_ph2_in = ctrl_r[`BF_CTRL_START_PH2];
  assign link.start_ph3_in = ctrl_r[`BF_CTRL_START_PH3];
  assign link.residual_start_in = ctrl_r[`BF_CTRL_RES_START];
  assign link.bf_inhibit_in = ctrl_r[`BF_CTRL_INHIBIT];
  assign link.breaker_closed_in = ctrl_r[`BF_CTRL_CLOSED];
  assign link.breaker_closed_ph1_in = ctrl_r[`BF_CTRL_CLOSED_PH1];
  assign link.breaker_closed_ph2_in = ctrl_r[`BF_CTRL_CLOSED_PH2];
  assign link.breaker_closed_ph3_in = ctrl_r[`BF_CTRL_CLOSED_PH3];
  assign link.op_mode = mode_r;
  assign link.retrip_en = retrip_en_r;
  assign link.retrip_delay = retrip_dly_r;
  assign link.backup_delay = backup_dly_r;
  assign link.pulse_duration = pulse_r;
  assign link.ph_threshold = ph_thr_r;
  assign link.res_threshold = res_thr_r;
endmodule : bf_requester

/* File: bf_link_sva.sv */
// Concurrent checks on the breaker failure link
`include "bf_map.svh"
module bf_link_sva #(
  parameter int unsigned TICK_CYCLES = `BF_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Requests and settings
  input wire logic common_start_in,
  input wire logic start_ph1_in,
  input wire logic start_ph2_in,
  input wire logic start_ph3_in,
  input wire logic residual_start_in,
  input wire logic bf_inhibit_in,
  input wire bf_pkg::op_mode_type op_mode,
  input wire logic retrip_en,
  input wire bf_pkg::ms_type retrip_delay,
  input wire bf_pkg::ms_type backup_delay,
  input wire bf_pkg::ms_type pulse_duration,
  // Trips and events
  input wire logic backup_trip_out,
  input wire logic retrip_ph1_out,
  input wire logic retrip_ph2_out,
  input wire logic retrip_ph3_out,
  input wire logic [3:0] event_on,
  input wire logic [3:0] event_off
);
  localparam int TK = int'(TICK_CYCLES);
  int run_cnt;
  int high_cnt;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Cycles with any start active
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !(common_start_in | start_ph1_in | start_ph2_in | start_ph3_in
        | residual_start_in))
      run_cnt <= 0;
    else
      run_cnt <= run_cnt + 1;
  end
  // Cycles with backup trip high
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !backup_trip_out)
      high_cnt <= 0;
    else
      high_cnt <= high_cnt + 1;
  end
  property p_off_quiet;
    op_mode == bf_pkg::op_off |=> !(backup_trip_out | retrip_ph1_out | retrip_ph2_out
      | retrip_ph3_out);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("Trip while off");
  property p_inhibit;
    bf_inhibit_in |=> !(backup_trip_out | retrip_ph1_out | retrip_ph2_out | retrip_ph3_out);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("Trip while inhibited");
  property p_bu_event_on;
    $rose(backup_trip_out) |=> event_on[0];
  endproperty
  a_bu_event_on: assert property (p_bu_event_on) else $error("No on event");
  property p_bu_event_off;
    $fell(backup_trip_out) |=> event_off[0];
  endproperty
  a_bu_event_off: assert property (p_bu_event_off) else $error("No off event");
  property p_rt_en;
    $rose(retrip_ph1_out) |-> $past(retrip_en, 2);
  endproperty
  a_rt_en: assert property (p_rt_en) else $error("Retrip while disabled");
  property p_pulse_min;
    $fell(backup_trip_out) && !$past(bf_inhibit_in) && $past(op_mode) != bf_pkg::op_off
      |-> high_cnt >= (int'(pulse_duration) - 1) * TK;
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("Trip pulse too short");
  property p_bu_not_early;
    $rose(backup_trip_out) |-> run_cnt >= (int'(backup_delay) - 1) * TK;
  endproperty
  a_bu_not_early: assert property (p_bu_not_early) else $error("Backup early");
  property p_rt_not_early;
    $rose(retrip_ph1_out) |-> run_cnt >= (int'(retrip_delay) - 1) * TK;
  endproperty
  a_rt_not_early: assert property (p_rt_not_early) else $error("Retrip early");
endmodule : bf_link_sva

/* File: breaker_failure_trip_logic_test.sv */
// Self-checking bench for the breaker failure link
`include "bf_map.svh"
module breaker_failure_trip_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 20;
  localparam logic [31:0] DFLT [8] = '{32'h00000000, 32'(`BF_RETRIP_DLY_RST),
    32'(`BF_BACKUP_DLY_RST), 32'(`BF_PULSE_RST), 32'(`BF_PH_THR_RST), 32'(`BF_RES_THR_RST),
    32'h00000000, 32'h00000000};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] meas [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic [15:0] meas_res = 16'h0000;
  logic [31:0] seed = 32'ha1c3d0a6;
  logic [31:0] q;
  int err_total = 0;
  int total_checks = 0;
  int pulse_ms = 0;
  int rt_ms = 0;
  bf_if link ();
  bf_device #(.TICK_CYCLES(TK)) i_bf_device (.sys_clk(sys_clk), .rst_n(rst_n),
    .meas_ph1(meas[0]), .meas_ph2(meas[1]), .meas_ph3(meas[2]), .meas_res(meas_res),
    .link(link));
  bf_requester i_bf_requester (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
  bf_link_sva #(.TICK_CYCLES(TK)) i_bf_link_sva (.sys_clk(sys_clk), .rst_n(rst_n),
    .common_start_in(link.common_start_in), .start_ph1_in(link.start_ph1_in),
    .start_ph2_in(link.start_ph2_in), .start_ph3_in(link.start_ph3_in),
    .residual_start_in(link.residual_start_in), .bf_inhibit_in(link.bf_inhibit_in),
    .op_mode(link.op_mode), .retrip_en(link.retrip_en), .retrip_delay(link.retrip_delay),
    .backup_delay(link.backup_delay), .pulse_duration(link.pulse_duration),
    .backup_trip_out(link.backup_trip_out), .retrip_ph1_out(link.retrip_ph1_out),
    .retrip_ph2_out(link.retrip_ph2_out), .retrip_ph3_out(link.retrip_ph3_out),
    .event_on(link.event_on), .event_off(link.event_off));

  always #25 sys_clk = ~sys_clk;

  function automatic int rnd(input int m);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed[15:0]) % m;
  endfunction : rnd

  function automatic logic exp_trip(input int md, input logic cur);
    return md == 3 || (cur ? md == 1 : md == 2);
  endfunction : exp_trip

  function automatic logic in_win(input int t, input int ms);
    return t >= (ms - 1) * TK && t <= ms * TK + 6;
  endfunction : in_win

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      err_total++;
      give_verdict();
    end
    @(posedge sys_clk);
  endtask : bus

  task automatic run_fault(input logic [31:0] ctrl, input logic [15:0] drop,
    input logic exp_bu, input logic [2:0] exp_rt);
    int t_bu;
    int t_rt;
    int h;
    logic [2:0] rt;
    logic [2:0] seen;
    t_bu = -1;
    t_rt = -1;
    rt = 3'b000;
    bus(1'b0, `BF_OFS_CTRL, ctrl);
    for (int n = 1; n <= 103 * TK; n++)
    begin
      @(posedge sys_clk);
      if (n == 600)
        meas_res <= drop;
      seen = {link.retrip_ph3_out, link.retrip_ph2_out, link.retrip_ph1_out};
      if (link.backup_trip_out === 1'b1 && t_bu < 0)
        t_bu = n;
      if (seen !== 3'b000 && t_rt < 0)
        t_rt = n;
      rt = rt | seen;
    end
    check(32'(t_bu >= 0), 32'(exp_bu));
    check(32'(rt), 32'(exp_rt));
    if (exp_bu)
      check(32'(in_win(t_bu, 100)), 32'h00000001);
    if (exp_rt != 3'b000)
      check(32'(in_win(t_rt, rt_ms)), 32'h00000001);
    meas <= '{16'h0000, 16'h0000, 16'h0000};
    meas_res <= 16'h0000;
    bus(1'b0, `BF_OFS_CTRL, 32'h00000000);
    h = 0;
    while (exp_bu && link.backup_trip_out === 1'b1 && h < (pulse_ms + 3) * TK)
    begin
      @(posedge sys_clk);
      h++;
    end
    if (h >= (pulse_ms + 3) * TK)
    begin
      err_total++;
      give_verdict();
    end
    if (exp_bu)
    begin
      check(32'(h >= pulse_ms * TK - 4 && h <= (pulse_ms + 1) * TK + 4), 32'h00000001);
      repeat (2) @(posedge sys_clk);
      bus(1'b1, `BF_OFS_STATUS, 32'h00000000);
      check(q & 32'h0000ffff, {16'h0000, exp_rt, 1'b1, exp_rt, 1'b1, 8'h00});
    end
    bus(1'b0, `BF_OFS_STATUS, 32'h0000ff00);
    bus(1'b0, `BF_OFS_MODE, 32'h00000000);
  endtask : run_fault

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check({28'h0000000, link.backup_trip_out, link.retrip_ph1_out, link.retrip_ph2_out,
      link.retrip_ph3_out}, 32'h00000000);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 8'(4 + 4 * i), 32'h00000000);
      check(q, DFLT[i]);
    end
    bus(1'b0, 8'h20, 32'hffffffff);
    bus(1'b1, 8'h20, 32'h00000000);
    check(q, 32'h00000000);
    $display("Test defaults finished");
    bus(1'b0, `BF_OFS_BACKUP_DLY, 32'h00000064);
    for (int k = 0; k < 8; k++)
    begin
      pulse_ms = rnd(5);
      bus(1'b0, `BF_OFS_PULSE, pulse_ms);
      bus(1'b0, `BF_OFS_MODE, k % 4);
      if (k < 4)
        meas[0] <= 16'(30 + rnd(170));
      run_fault(k < 4 ? 32'h2 : (k % 2 == 1 ? 32'h42 : 32'h82), 16'h0000,
        exp_trip(k % 4, k < 4), 3'b000);
    end
    $display("Test modes finished");
    for (int p = 0; p < 4; p++)
    begin
      rt_ms = rnd(21);
      bus(1'b0, `BF_OFS_RETRIP_DLY, rt_ms);
      bus(1'b0, `BF_OFS_MODE, 32'h00000011);
      foreach (meas[j])
        meas[j] <= (p == 0 || p == j + 1) ? 16'(30 + rnd(170)) : 16'h0000;
      run_fault(32'h1 << p, 16'h0000, 1'b1, p == 0 ? 3'b111 : 3'b001 << (p - 1));
    end
    $display("Test retrip finished");
    bus(1'b0, `BF_OFS_MODE, 32'h00000001);
    meas[0] <= 16'h0064;
    run_fault(32'h22, 16'h0000, 1'b0, 3'b000);
    $display("Test inhibit finished");
    for (int r = 0; r < 2; r++)
    begin
      bus(1'b0, `BF_OFS_MODE, 32'h00000001);
      meas_res <= 16'h0014;
      run_fault(32'h10, r == 0 ? 16'h0012 : 16'h0011, r == 0, 3'b000);
    end
    $display("Test residual finished");
    give_verdict();
  end
endmodule : breaker_failure_trip_logic_test
